// >>> verilog/bls_pkg.sv
package bls_pkg;
  localparam int unsigned CLK_HZ          = 25000000;
  localparam int unsigned DISCHARGE_MS    = 400;
  localparam int unsigned SOFTSTART_MS    = 25;
  localparam int unsigned BOOSTSU_MS      = 50;
  localparam int unsigned RECOVERY_MS     = 100;
  localparam int unsigned SHORT_MS        = 5;
  localparam int unsigned BUSTO_MS        = 500;
  localparam int unsigned DISCHARGE_CYC   = DISCHARGE_MS * (CLK_HZ / 1000);
  localparam int unsigned SOFTSTART_CYC   = SOFTSTART_MS * (CLK_HZ / 1000);
  localparam int unsigned BOOSTSU_CYC     = BOOSTSU_MS * (CLK_HZ / 1000);
  localparam int unsigned RECOVERY_CYC    = RECOVERY_MS * (CLK_HZ / 1000);
  localparam int unsigned SHORT_CYC       = SHORT_MS * (CLK_HZ / 1000);
  localparam int unsigned BUSTO_CYC       = BUSTO_MS * (CLK_HZ / 1000);
  localparam int unsigned NCH             = 4;
  localparam logic [11:0] CURRENT_SET_PIN_SHORT_CODE = 12'h3FF;
  localparam logic [7:0]  CURRENT_SET_PIN_LIMIT_MA   = 8'h46;
  localparam logic [1:0]  INTEN_DIS_WR    = 2'h1;
  localparam logic [1:0]  INTEN_EN_WR     = 2'h3;
  localparam logic [1:0]  INTEN_EN_RD     = 2'h2;
  localparam logic [1:0]  INTEN_DIS_RD    = 2'h0;
  localparam logic [31:0] ADDR_CTRL       = 32'h0000_0000;
  localparam logic [31:0] ADDR_STATUS     = 32'h0000_0004;
  localparam logic [31:0] ADDR_INTEN      = 32'h0000_0008;
  localparam logic [31:0] ADDR_STATE      = 32'h0000_000C;
  localparam int unsigned F_CURRENT_SET_PIN          = 0;
  localparam int unsigned F_TSD           = 1;
  localparam int unsigned F_OPEN          = 2;
  localparam int unsigned F_ISHORT        = 3;
  localparam int unsigned F_GND           = 4;
  localparam int unsigned F_INV           = 5;
  localparam int unsigned F_BUSTO         = 6;
  localparam int unsigned NFLT            = 7;
  localparam int unsigned CLR_POS         = 16;
  localparam logic [NFLT-1:0] INTEN_RST   = 7'h7F;
  typedef enum logic [2:0] {
    ST_SHUTDOWN = 3'h0,
    ST_INIT     = 3'h1,
    ST_STANDBY  = 3'h3,
    ST_SOFT     = 3'h2,
    ST_BOOSTSU  = 3'h6,
    ST_NORMAL   = 3'h7,
    ST_RECOVER  = 3'h5,
    ST_LATCH    = 3'h4
  } bls_state_t;
endpackage : bls_pkg

// >>> verilog/bls_seq.sv
`timescale 1ns/1ns
module bls_seq (
  input  wire logic                    core_clk,
  input  wire logic                    rst_b,
  input  wire logic                    haddr_sel,
  input  wire logic [31:0]             haddr,
  input  wire logic [1:0]              htrans,
  input  wire logic                    hwrite,
  input  wire logic [2:0]              hsize,
  input  wire logic [31:0]             hwdata,
  input  wire logic                    hready,
  output logic [31:0]                  hrdata,
  output logic                         hreadyout,
  output logic                         hresp,
  input  wire logic                    enable_pin,
  input  wire logic                    brightness_nz,
  input  wire logic                    init_done,
  input  wire logic                    current_set_pin_low,
  input  wire logic                    overtemp,
  input  wire logic                    supply_fault,
  input  wire logic                    boost_fault,
  input  wire logic [bls_pkg::NCH-1:0] headroom_low,
  input  wire logic                    boost_at_max,
  input  wire logic [bls_pkg::NCH-1:0] above_string_short_level,
  input  wire logic [bls_pkg::NCH-1:0] below_ground_short_level,
  input  wire logic [bls_pkg::NCH-1:0] used_mask,
  input  wire logic [bls_pkg::NCH-1:0] unused_not_grounded,
  input  wire logic                    bus_cmd_active,
  input  wire logic                    bus_stop_seen,
  output logic                         int_out,
  output logic                         regulator_on,
  output logic                         config_load,
  output logic                         resistor_detect,
  output logic                         cfg_write_ok,
  output logic                         power_line_switch_on,
  output logic                         boost_on,
  output logic                         boost_reduced_ilim,
  output logic                         boost_discharge,
  output logic                         led_drivers_on,
  output logic [bls_pkg::NCH-1:0]      string_enable,
  output logic [bls_pkg::NCH-1:0]      test_current_on,
  output logic                         supply_checks_on,
  output logic                         boost_checks_on,
  output logic                         led_checks_on,
  output logic                         current_limit_on,
  output logic [11:0]                  string_current_code,
  output logic                         serial_reset,
  output bls_pkg::bls_state_t          state_out
);
  import bls_pkg::*;

  typedef struct packed {
    bls_state_t            st;
    logic [31:0]           tmr;
    logic [31:0]           bus_tmr;
    logic [NCH-1:0][31:0]  sh_tmr;
    logic [NCH-1:0]        dis;
    logic [NFLT-1:0]       flg;
    logic [NFLT-1:0]       inten;
    logic [NFLT-1:0]       prev;
    logic [11:0]           cur_code;
    logic                  ph_wr;
    logic                  ph_rd;
    logic [3:0]            ph_addr;
    logic [31:0]           rdata;
    logic                  intr;
    logic                  ser_rst;
  } bls_reg_t;

  bls_reg_t s_r;
  bls_reg_t s_nxt;

  function automatic logic [1:0] inten_rd(input logic en);
    inten_rd = en ? INTEN_EN_RD : INTEN_DIS_RD;
  endfunction : inten_rd

  function automatic logic tmr_done(input logic [31:0] t, input int unsigned lim);
    tmr_done = (t >= lim - 1);
  endfunction : tmr_done

  function automatic logic in_active(input bls_state_t st);
    in_active = (st == ST_SOFT) || (st == ST_BOOSTSU) || (st == ST_NORMAL);
  endfunction : in_active

  function automatic logic in_boost(input bls_state_t st);
    in_boost = (st == ST_BOOSTSU) || (st == ST_NORMAL);
  endfunction : in_boost

  // only the low register words answer; anything above them reads zero
  function automatic logic bus_hit(input logic rdy, input logic sel, input logic [1:0] tr,
                                   input logic [31:0] a);
    bus_hit = rdy && sel && tr[1] && (a[31:4] == 28'h0);
  endfunction : bus_hit

  logic [NFLT-1:0] ev;
  logic            act;
  logic            rec_flt;
  logic [NCH-1:0]  others_low;
  logic [31:0]     ie_rd;
  integer          i;

  always_comb begin
    s_nxt      = s_r;
    ev         = '0;
    ie_rd      = '0;
    others_low = '0;
    act        = in_active(s_r.st);
    // fault events
    ev[F_CURRENT_SET_PIN] = current_set_pin_low;
    ev[F_TSD]  = overtemp && s_r.st != ST_SHUTDOWN && s_r.st != ST_INIT;
    for (i = 0; i < NCH; i++) begin
      others_low[i] = |(~above_string_short_level & used_mask & ~s_r.dis
                        & ~(NCH'(1) << i));
      if (s_r.st == ST_NORMAL && used_mask[i] && !s_r.dis[i] && headroom_low[i]
          && boost_at_max) begin
        s_nxt.dis[i] = 1'b1;
        ev[F_OPEN]   = 1'b1;
      end
      if (s_r.st == ST_NORMAL && used_mask[i] && !s_r.dis[i]
          && above_string_short_level[i] && others_low[i]) begin
        if (tmr_done(s_r.sh_tmr[i], SHORT_CYC)) begin
          s_nxt.dis[i] = 1'b1;
          ev[F_ISHORT] = 1'b1;
        end else begin
          s_nxt.sh_tmr[i] = s_r.sh_tmr[i] + 32'h1;
        end
      end else begin
        s_nxt.sh_tmr[i] = '0;
      end
    end
    if (s_r.st == ST_SOFT && |(below_ground_short_level & used_mask)) begin
      ev[F_GND] = 1'b1;
    end
    if (in_boost(s_r.st) && |(below_ground_short_level & used_mask & s_r.dis)) begin
      ev[F_GND] = 1'b1;
    end
    // only channels that are switched off carry the test current
    if (in_boost(s_r.st)
        && |(below_ground_short_level & used_mask & ~string_enable)) begin
      ev[F_GND] = 1'b1;
    end
    ev[F_INV] = |(unused_not_grounded & ~used_mask) && s_r.st != ST_SHUTDOWN;
    // bus timeout watchdog
    s_nxt.ser_rst = 1'b0;
    if (bus_cmd_active && !bus_stop_seen && !s_r.ser_rst) begin
      if (tmr_done(s_r.bus_tmr, BUSTO_CYC)) begin
        ev[F_BUSTO]   = 1'b1;
        s_nxt.ser_rst = 1'b1;
        s_nxt.bus_tmr = '0;
      end else begin
        s_nxt.bus_tmr = s_r.bus_tmr + 32'h1;
      end
    end else begin
      s_nxt.bus_tmr = '0;
    end
    if (ev[F_CURRENT_SET_PIN]) begin
      s_nxt.cur_code = CURRENT_SET_PIN_SHORT_CODE;
    end
    rec_flt = ev[F_GND] || (act && supply_fault) || (in_boost(s_r.st) && boost_fault);
    // state machine
    s_nxt.tmr = s_r.tmr + 32'h1;
    unique case (s_r.st)
      ST_SHUTDOWN: begin
        if (enable_pin) begin
          s_nxt.st  = ST_INIT;
          s_nxt.tmr = '0;
          s_nxt.dis = '0;
        end
      end
      ST_INIT: begin
        if (init_done) begin
          s_nxt.st = ST_STANDBY;
        end
      end
      ST_STANDBY: begin
        if (!overtemp && !supply_fault) begin
          s_nxt.st  = ST_SOFT;
          s_nxt.tmr = '0;
        end
      end
      ST_SOFT: begin
        if (tmr_done(s_r.tmr, SOFTSTART_CYC)) begin
          s_nxt.st  = ST_BOOSTSU;
          s_nxt.tmr = '0;
        end
      end
      ST_BOOSTSU: begin
        if (tmr_done(s_r.tmr, BOOSTSU_CYC)) begin
          s_nxt.st  = ST_NORMAL;
          s_nxt.tmr = '0;
        end
      end
      ST_NORMAL: begin
        if (&(s_nxt.dis | ~used_mask)) begin
          s_nxt.st = ST_LATCH;
        end
      end
      ST_RECOVER: begin
        if (tmr_done(s_r.tmr, RECOVERY_CYC)) begin
          s_nxt.tmr = '0;
          if (brightness_nz) begin
            s_nxt.st = ST_STANDBY;
          end
        end
      end
      ST_LATCH: begin
      end
    endcase
    if (act && rec_flt) begin
      s_nxt.st  = ST_RECOVER;
      s_nxt.tmr = '0;
    end
    if (act && ev[F_TSD]) begin
      s_nxt.st = ST_STANDBY;
    end
    if (!enable_pin && s_r.st != ST_SHUTDOWN) begin
      s_nxt.st  = ST_SHUTDOWN;
      s_nxt.tmr = '0;
    end
    if (s_r.st == ST_SHUTDOWN && s_r.tmr >= DISCHARGE_CYC) begin
      s_nxt.tmr = s_r.tmr;
    end
    // AHB-Lite slave
    s_nxt.ph_wr = 1'b0;
    s_nxt.ph_rd = 1'b0;
    if (bus_hit(hready, haddr_sel, htrans, haddr)) begin
      s_nxt.ph_wr   = hwrite;
      s_nxt.ph_rd   = !hwrite;
      s_nxt.ph_addr = haddr[3:0];
    end
    for (i = 0; i < NFLT; i++) begin
      ie_rd[2*i +: 2] = inten_rd(s_r.inten[i]);
    end
    if (s_r.ph_wr) begin
      unique case (s_r.ph_addr)
        ADDR_STATUS[3:0]: begin
          for (i = 0; i < NFLT; i++) begin
            if (hwdata[i] && hwdata[CLR_POS + i]) begin
              s_nxt.flg[i] = 1'b0;
            end
          end
        end
        ADDR_INTEN[3:0]: begin
          for (i = 0; i < NFLT; i++) begin
            if (hwdata[2*i +: 2] == INTEN_EN_WR) begin
              s_nxt.inten[i] = 1'b1;
            end else if (hwdata[2*i +: 2] == INTEN_DIS_WR) begin
              s_nxt.inten[i] = 1'b0;
            end
          end
        end
        ADDR_CTRL[3:0]: begin
          // the short clamp wins over a host write
          if (s_r.st != ST_SHUTDOWN && s_r.st != ST_INIT && !ev[F_CURRENT_SET_PIN]) begin
            s_nxt.cur_code = hwdata[11:0];
          end
        end
        default: begin
        end
      endcase
    end
    // a fault event wins over a clear in the same cycle
    s_nxt.flg  = s_nxt.flg | ev;
    s_nxt.prev = ev;
    s_nxt.rdata = '0;
    if (bus_hit(hready, haddr_sel, htrans, haddr) && !hwrite) begin
      unique case (haddr[3:0])
        ADDR_CTRL[3:0]:   s_nxt.rdata = {20'h0, s_nxt.cur_code};
        ADDR_STATUS[3:0]: s_nxt.rdata = {{(32-NFLT){1'b0}}, s_nxt.flg};
        ADDR_INTEN[3:0]:  s_nxt.rdata = ie_rd;
        ADDR_STATE[3:0]:  s_nxt.rdata = {25'h0, s_r.dis, s_r.st};
        default:          s_nxt.rdata = '0;
      endcase
    end
    s_nxt.intr = |(s_nxt.flg & s_nxt.inten);
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      s_r          <= '0;
      s_r.st       <= ST_SHUTDOWN;
      s_r.inten    <= INTEN_RST;
      s_r.tmr      <= DISCHARGE_CYC;
    end else begin
      s_r <= s_nxt;
    end
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      regulator_on         <= 1'b0;
      config_load          <= 1'b0;
      resistor_detect      <= 1'b0;
      cfg_write_ok         <= 1'b0;
      power_line_switch_on <= 1'b0;
      boost_on             <= 1'b0;
      boost_reduced_ilim   <= 1'b0;
      boost_discharge      <= 1'b0;
      led_drivers_on       <= 1'b0;
      string_enable        <= '0;
      test_current_on      <= '0;
      supply_checks_on     <= 1'b0;
      boost_checks_on      <= 1'b0;
      led_checks_on        <= 1'b0;
      current_limit_on     <= 1'b0;
      string_current_code  <= '0;
      serial_reset         <= 1'b0;
      state_out            <= ST_SHUTDOWN;
      int_out              <= 1'b0;
      hrdata               <= '0;
      hreadyout            <= 1'b1;
      hresp                <= 1'b0;
    end else begin
      regulator_on         <= s_nxt.st != ST_SHUTDOWN;
      config_load          <= s_nxt.st == ST_INIT;
      resistor_detect      <= s_nxt.st == ST_INIT;
      cfg_write_ok         <= s_nxt.st != ST_SHUTDOWN && s_nxt.st != ST_INIT;
      power_line_switch_on <= in_active(s_nxt.st);
      boost_on             <= in_boost(s_nxt.st);
      boost_reduced_ilim   <= s_nxt.st == ST_BOOSTSU;
      boost_discharge      <= s_nxt.st == ST_SHUTDOWN && s_nxt.tmr < DISCHARGE_CYC;
      led_drivers_on       <= s_nxt.st == ST_NORMAL && brightness_nz;
      string_enable        <= (s_nxt.st == ST_NORMAL && brightness_nz)
                              ? (used_mask & ~s_nxt.dis) : '0;
      test_current_on      <= (s_nxt.st == ST_SOFT) ? used_mask
                              : ((s_nxt.st == ST_BOOSTSU || s_nxt.st == ST_NORMAL)
                                 ? used_mask & ~((s_nxt.st == ST_NORMAL && brightness_nz)
                                   ? ~s_nxt.dis : '0) : '0);
      supply_checks_on     <= in_active(s_nxt.st);
      boost_checks_on      <= in_boost(s_nxt.st);
      led_checks_on        <= s_nxt.st == ST_NORMAL;
      current_limit_on     <= s_nxt.flg[F_CURRENT_SET_PIN];
      string_current_code  <= s_nxt.cur_code;
      serial_reset         <= s_nxt.ser_rst;
      state_out            <= s_nxt.st;
      int_out              <= s_nxt.intr;
      hrdata               <= s_nxt.rdata;
      hreadyout            <= 1'b1;
      hresp                <= 1'b0;
    end
  end
endmodule : bls_seq

// >>> verification/bls_seq_sva.sv
`timescale 1ns/1ns
module bls_seq_sva (
  input wire logic                    core_clk,
  input wire logic                    rst_b,
  input wire logic                    enable_pin,
  input wire logic                    overtemp,
  input wire logic                    supply_fault,
  input wire logic                    current_set_pin_low,
  input wire logic [bls_pkg::NCH-1:0] below_ground_short_level,
  input wire logic [bls_pkg::NCH-1:0] used_mask,
  input wire logic                    cfg_write_ok,
  input wire logic                    power_line_switch_on,
  input wire logic                    boost_on,
  input wire logic                    led_drivers_on,
  input wire logic                    supply_checks_on,
  input wire logic                    resistor_detect,
  input wire logic [11:0]             string_current_code,
  input wire logic                    current_limit_on,
  input wire bls_pkg::bls_state_t     state_out
);
  import bls_pkg::*;
  logic [31:0] rec_cnt_r;
  logic [31:0] rec_cnt_nxt;
  // cycles spent in recovery so far
  always_comb rec_cnt_nxt = (state_out == ST_RECOVER) ? rec_cnt_r + 32'h1 : 32'h0;
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) rec_cnt_r <= 32'h0;
    else rec_cnt_r <= rec_cnt_nxt;
  end
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_b);
  a_en_low_down: assert property (
    $fell(enable_pin) |-> ##[1:2] state_out == ST_SHUTDOWN) else $error("no shutdown");
  a_power_off: assert property (
    state_out inside {ST_SHUTDOWN, ST_RECOVER} |->
    !(boost_on || power_line_switch_on || led_drivers_on)) else $error("power left on");
  a_recover_time: assert property (
    $past(state_out) == ST_RECOVER && state_out == ST_STANDBY |->
    rec_cnt_r >= RECOVERY_CYC - 1) else $error("recovery too short");
  a_cfg_gate: assert property (
    state_out inside {ST_SHUTDOWN, ST_INIT} |-> !cfg_write_ok) else $error("early cfg");
  a_init_detect: assert property (
    state_out == ST_INIT |-> resistor_detect) else $error("no detection in init");
  a_standby_go: assert property (
    state_out == ST_STANDBY && !overtemp && !supply_fault |-> ##[1:2]
    state_out != ST_STANDBY) else $error("standby held");
  a_soft_checks: assert property (
    state_out == ST_SOFT |-> supply_checks_on && power_line_switch_on)
    else $error("soft start checks off");
  a_soft_gnd: assert property (
    state_out == ST_SOFT && |(below_ground_short_level & used_mask) |-> ##[1:3]
    state_out == ST_RECOVER) else $error("ground short missed");
  a_current_set_pin_clamp: assert property (
    current_set_pin_low |-> ##[1:2] string_current_code == CURRENT_SET_PIN_SHORT_CODE &&
    current_limit_on) else $error("current not clamped");
  a_hot_standby: assert property (
    overtemp && state_out inside {ST_SOFT, ST_BOOSTSU, ST_NORMAL} |-> ##[1:2]
    state_out == ST_STANDBY) else $error("overtemp missed");
  a_latch_hold: assert property (
    state_out == ST_LATCH && enable_pin |=> state_out == ST_LATCH) else $error("latch left");
endmodule : bls_seq_sva

// >>> verification/bls_host.sv
`timescale 1ns/1ns
module bls_host (
  input  wire logic        core_clk,
  input  wire logic        hready,
  input  wire logic [31:0] hrdata,
  output logic             haddr_sel,
  output logic [31:0]      haddr,
  output logic [1:0]       htrans,
  output logic             hwrite,
  output logic [2:0]       hsize,
  output logic [31:0]      hwdata,
  output logic             enable_pin
);
  initial begin
    haddr_sel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
    enable_pin = 1'b0;
  end
  // host level on the enable pin
  task automatic set_en(input logic v);
    @(posedge core_clk);
    enable_pin <= v;
  endtask : set_en
  // one word transfer; each phase held until hready is sampled high or 16 cycles pass
  task automatic xfer(input logic wr, input logic [31:0] a, input logic [31:0] d,
                      output logic [31:0] q, output logic ok);
    int n;
    @(posedge core_clk);
    haddr_sel <= 1'b1;
    haddr <= a;
    htrans <= 2'h2;
    hwrite <= wr;
    n = 0;
    do begin
      @(posedge core_clk);
      n++;
    end while (hready !== 1'b1 && n < 16);
    ok = (hready === 1'b1);
    haddr_sel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    n = 0;
    do begin
      @(posedge core_clk);
      n++;
    end while (hready !== 1'b1 && n < 16);
    ok = ok && (hready === 1'b1);
    q = hrdata;
    hwdata <= ~d;
  endtask : xfer
endmodule : bls_host

// >>> verification/bls_seq_tb_top.sv
`timescale 1ns/1ns
module bls_seq_tb_top;
  import bls_pkg::*;
  logic           core_clk, rst_b, haddr_sel, hwrite, hreadyout, hresp, ok;
  logic [31:0]    haddr, hwdata, hrdata, q;
  logic [1:0]     htrans;
  logic [2:0]     hsize;
  logic           enable_pin, brightness_nz, init_done, current_set_pin_low, overtemp;
  logic           supply_fault, boost_fault, boost_at_max, bus_cmd_active, bus_stop_seen;
  logic [NCH-1:0] headroom_low, above_string_short_level, below_ground_short_level;
  logic [NCH-1:0] used_mask, unused_not_grounded, string_enable, test_current_on;
  logic           int_out, regulator_on, config_load, resistor_detect, cfg_write_ok;
  logic           power_line_switch_on, boost_on, boost_reduced_ilim, boost_discharge;
  logic           led_drivers_on, supply_checks_on, boost_checks_on, led_checks_on;
  logic           current_limit_on, serial_reset;
  logic [11:0]    string_current_code;
  bls_state_t     state_out;
  int             errors, n_compared;
  bls_seq i_dut (.core_clk, .rst_b, .haddr_sel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
    .hready(hreadyout), .hrdata, .hreadyout, .hresp, .enable_pin, .brightness_nz, .init_done,
    .current_set_pin_low, .overtemp, .supply_fault, .boost_fault, .headroom_low, .boost_at_max,
    .above_string_short_level, .below_ground_short_level, .used_mask, .unused_not_grounded,
    .bus_cmd_active, .bus_stop_seen, .int_out, .regulator_on, .config_load, .resistor_detect,
    .cfg_write_ok, .power_line_switch_on, .boost_on, .boost_reduced_ilim, .boost_discharge,
    .led_drivers_on, .string_enable, .test_current_on, .supply_checks_on, .boost_checks_on,
    .led_checks_on, .current_limit_on, .string_current_code, .serial_reset, .state_out);
  bls_host i_host (.core_clk, .hready(hreadyout), .hrdata, .haddr_sel, .haddr, .htrans,
    .hwrite, .hsize, .hwdata, .enable_pin);
  initial begin
    core_clk = 1'b0;
    forever #20 core_clk = ~core_clk;
  end
  task automatic test_done();
    $display("compared %0d errors %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : test_done
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      errors++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic hang();
    errors++;
    test_done();
  endtask : hang
  task automatic tk(input int n);
    repeat (n) @(negedge core_clk);
  endtask : tk
  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    i_host.xfer(1'b1, a, d, q, ok);
    if (!ok) hang();
  endtask : wr
  task automatic rd(input logic [31:0] a, input logic [31:0] exp);
    i_host.xfer(1'b0, a, 32'h0, q, ok);
    if (!ok) hang();
    chk(q, exp);
  endtask : rd
  // bounded wait for a state, then settle to the falling edge
  task automatic wait_st(input bls_state_t s);
    int n;
    n = 0;
    while (state_out !== s && n < 64) begin
      @(posedge core_clk);
      n++;
    end
    if (state_out !== s) hang();
    @(negedge core_clk);
    chk(state_out, s);
  endtask : wait_st
  initial begin
    {rst_b, brightness_nz, init_done, current_set_pin_low, overtemp, supply_fault} = 6'h0;
    {boost_fault, boost_at_max, bus_cmd_active, bus_stop_seen} = 4'h0;
    {headroom_low, above_string_short_level, below_ground_short_level} = 12'h0;
    unused_not_grounded = 4'h0;
    used_mask = 4'hF;
    errors = 0;
    n_compared = 0;
    repeat (10) @(posedge core_clk);
    rst_b <= 1'b1;
    brightness_nz <= 1'b1;
    bus_cmd_active <= 1'b1;
    repeat (8) @(posedge core_clk);
    bus_stop_seen <= 1'b1;
    @(posedge core_clk);
    {bus_cmd_active, bus_stop_seen} <= 2'h0;
    rd(ADDR_STATE, 32'h0);
    rd(ADDR_INTEN, 32'h2AAA);
    rd(ADDR_STATUS, 32'h0);
    rd(32'h0000_0010, 32'h0);
    wr(ADDR_CTRL, 32'h0000_0123);
    rd(ADDR_CTRL, 32'h0);
    $display("test reset done");
    i_host.set_en(1'b1);
    wait_st(ST_INIT);
    chk({regulator_on, config_load, resistor_detect, cfg_write_ok}, 4'hE);
    @(posedge core_clk);
    init_done <= 1'b1;
    wait_st(ST_SOFT);
    chk({cfg_write_ok, power_line_switch_on, supply_checks_on, boost_on, boost_checks_on},
        5'h1C);
    chk({test_current_on, string_enable, led_checks_on, boost_reduced_ilim, hresp},
        {4'hF, 7'h0});
    wr(ADDR_CTRL, 32'h0000_0155);
    rd(ADDR_CTRL, 32'h0000_0155);
    wr(32'h0000_0010, 32'h0000_0AAA);
    rd(32'h0000_0010, 32'h0);
    rd(ADDR_CTRL, 32'h0000_0155);
    $display("test startup done");
    overtemp <= 1'b1;
    wait_st(ST_STANDBY);
    tk(20);
    chk({int_out, state_out}, {1'b1, ST_STANDBY});
    rd(ADDR_STATUS, 32'h2);
    overtemp <= 1'b0;
    wait_st(ST_SOFT);
    wr(ADDR_STATUS, 32'h0002_0000);
    wr(ADDR_STATUS, 32'h0000_0002);
    rd(ADDR_STATUS, 32'h2);
    wr(ADDR_STATUS, 32'h0002_0002);
    rd(ADDR_STATUS, 32'h0);
    tk(2);
    chk(int_out, 1'b0);
    $display("test overtemp done");
    wr(ADDR_INTEN, 32'h0000_0400);
    rd(ADDR_INTEN, 32'h22AA);
    used_mask <= 4'h7;
    unused_not_grounded <= 4'h8;
    tk(4);
    chk({int_out, state_out}, {1'b0, ST_SOFT});
    rd(ADDR_STATUS, 32'h20);
    wr(ADDR_INTEN, 32'h0000_0C00);
    tk(2);
    chk(int_out, 1'b1);
    @(posedge core_clk);
    unused_not_grounded <= 4'h0;
    wr(ADDR_STATUS, 32'h0020_0020);
    current_set_pin_low <= 1'b1;
    tk(4);
    chk({string_current_code, current_limit_on}, {CURRENT_SET_PIN_SHORT_CODE, 1'b1});
    chk(state_out, ST_SOFT);
    wr(ADDR_CTRL, 32'h0000_0012);
    rd(ADDR_CTRL, 32'h0000_03FF);
    rd(ADDR_STATUS, 32'h1);
    current_set_pin_low <= 1'b0;
    wr(ADDR_STATUS, 32'h0001_0001);
    $display("test flags done");
    supply_fault <= 1'b1;
    wait_st(ST_RECOVER);
    @(posedge core_clk);
    supply_fault <= 1'b0;
    tk(50);
    chk({state_out, led_drivers_on, boost_on, power_line_switch_on}, {ST_RECOVER, 3'h0});
    i_host.set_en(1'b0);
    wait_st(ST_SHUTDOWN);
    chk({boost_discharge, regulator_on, boost_on, power_line_switch_on, led_drivers_on},
        5'h10);
    i_host.set_en(1'b1);
    wait_st(ST_SOFT);
    wr(ADDR_INTEN, 32'h0000_0100);
    below_ground_short_level <= 4'h2;
    wait_st(ST_RECOVER);
    rd(ADDR_STATUS, 32'h10);
    chk(int_out, 1'b0);
    @(posedge core_clk);
    below_ground_short_level <= 4'h0;
    $display("test recovery done");
    test_done();
  end
endmodule : bls_seq_tb_top
bind bls_seq bls_seq_sva i_sva (.core_clk, .rst_b, .enable_pin, .overtemp, .supply_fault,
  .current_set_pin_low, .below_ground_short_level, .used_mask, .cfg_write_ok,
  .power_line_switch_on, .boost_on, .led_drivers_on, .supply_checks_on, .resistor_detect,
  .string_current_code, .current_limit_on, .state_out);
